// *** src/sltg_top.sv ***
// Test pattern generator for the transmit path of a serial converter link.
// Assumes word_advance pulses once per frame, symbol or octet, at most every other clock.

// How it works
// - Control low nibble picks pattern; zero is off.
// - Control bits five to four pick injection point.
// - Sample point: 16-bit word, one per frame.
// - Symbol point: 10-bit words, checker 155/2AA.
// - Octet point: 8-bit words, checker 55/AA.
// - Code 3: PN31, x31+x28+1, fixed seed.
// - Code 4: PN23, x23+x18+1, fixed seed.
// - Codes 5-7: PN15, PN9, PN7 with seeds.
// - Code 8: ramp wrapping at injection width.
// - Code E: user words one..four, repeating.
// - Code F: user words once, then zeros.
// - User words from registers, upper bits when narrower.
module sltg_top
	import sltg_pkg::*;
#(
	parameter int SAMPLE_W = 16
) (
	input wire logic clk, // 20 MHz clock
	input wire logic reset_n, // asynchronous reset, active low
	input wire logic [12:0] reg_addr, // register address
	input wire logic [7:0] reg_wdata, // register write data
	input wire logic reg_wr, // register write strobe
	input wire logic reg_rd, // register read strobe
	output logic [7:0] reg_rdata_q, // read data, two cycles after the strobe
	output logic reg_rvalid_q, // read data valid pulse
	input wire logic word_advance, // one pulse per frame, symbol or octet
	input wire logic [15:0] normal_word, // normal datapath word
	output logic [15:0] link_word_q, // word sent on, low-aligned
	output logic test_active_q, // test pattern replaces normal data
	output logic [1:0] inject_point_q // active injection point
);

	if (SAMPLE_W != 16) begin : g_bad_width
		$error("sltg_top serves only 16-bit samples");
	end

	function automatic sltg_poly_t poly_of(input logic [3:0] mode);
		sltg_poly_t p;
		p = '{order: 5'd31, tap: 5'd28, seed: SLTG_SEED_PN31};
		unique case (mode)
			SLTG_MODE_PN23: p = '{order: 5'd23, tap: 5'd18, seed: SLTG_SEED_PN23};
			SLTG_MODE_PN15: p = '{order: 5'd15, tap: 5'd14, seed: SLTG_SEED_PN15};
			SLTG_MODE_PN9: p = '{order: 5'd9, tap: 5'd5, seed: SLTG_SEED_PN9};
			SLTG_MODE_PN7: p = '{order: 5'd7, tap: 5'd6, seed: SLTG_SEED_PN7};
			default: p = '{order: 5'd31, tap: 5'd28, seed: SLTG_SEED_PN31};
		endcase
		return p;
	endfunction

	// Runs the register n steps; each step sends the bit leaving the LSB, so the seed goes out first.
	// The first bit sent ends in the word's MSB.
	function automatic sltg_prbs_t prbs_step(input logic [30:0] st, input sltg_poly_t p, input logic [4:0] n);
		sltg_prbs_t r;
		logic fb;
		r.state = st;
		r.word = 16'h0000;
		fb = 1'b0;
		for (int i = 0; i < 16; i++) begin
			if (5'(i) < n) begin
				fb = r.state[0] ^ r.state[p.order - p.tap];
				r.word = {r.word[14:0], r.state[0]};
				r.state = (r.state >> 1) | (31'(fb) << (p.order - 5'd1));
			end
		end
		return r;
	endfunction

	logic [7:0] ctrl_q;
	logic [30:0] prbs_q;
	logic [15:0] ramp_q;
	logic phase_q;
	logic [1:0] uidx_q;
	logic single_done_q;
	logic rd_pend_q;
	logic rd_is_upat_q;
	logic [7:0] rd_hold_q;
	logic [7:0] mem_byte;
	logic [15:0] mem_word;
	logic ctrl_wr;
	logic soft_reset;
	logic upat_hit_wr;
	logic upat_hit_rd;
	logic [2:0] wr_byte;
	logic [2:0] rd_byte;
	sltg_mode_t mode;
	sltg_inj_t inj;
	logic [4:0] width;
	logic [15:0] mask;
	logic [15:0] pat_word;
	logic [15:0] user_word;
	sltg_prbs_t prbs_next;
	logic is_prbs;
	sltg_poly_t wr_poly;

	assign mode = sltg_mode_t'(ctrl_q[SLTG_MODE_MSB:SLTG_MODE_LSB]);
	assign inj = sltg_inj_t'(ctrl_q[SLTG_INJ_MSB:SLTG_INJ_LSB]);
	assign ctrl_wr = reg_wr && (reg_addr == SLTG_ADDR_CTRL);
	assign soft_reset = reg_wr && (reg_addr == SLTG_ADDR_SOFT_RESET) && (reg_wdata == SLTG_SOFT_RESET_CODE);
	assign upat_hit_wr = reg_wr && (reg_addr >= SLTG_ADDR_UPAT_BASE) && (reg_addr <= SLTG_ADDR_UPAT_LAST);
	assign upat_hit_rd = (reg_addr >= SLTG_ADDR_UPAT_BASE) && (reg_addr <= SLTG_ADDR_UPAT_LAST);
	assign wr_byte = 3'(reg_addr - SLTG_ADDR_UPAT_BASE);
	assign rd_byte = wr_byte;
	assign is_prbs = (mode == SLTG_MODE_PN31) || (mode == SLTG_MODE_PN23) || (mode == SLTG_MODE_PN15)
		|| (mode == SLTG_MODE_PN9) || (mode == SLTG_MODE_PN7);

	sltg_upat_mem u_upat (
		.clk(clk),
		.reset_n(reset_n),
		.wr_en(upat_hit_wr),
		.wr_byte(wr_byte),
		.wr_data(reg_wdata),
		.rd_byte(rd_byte),
		.rd_byte_q(mem_byte),
		.rd_word(uidx_q),
		.rd_word_q(mem_word)
	);

	// Width and mask of the chosen injection point; an unused code falls back to samples.
	always_comb begin
		width = SLTG_W_SAMPLE;
		mask = SLTG_MASK_SAMPLE;
		user_word = mem_word;
		unique case (inj)
			SLTG_INJ_SYMBOL: begin
				width = SLTG_W_SYMBOL;
				mask = SLTG_MASK_SYMBOL;
				user_word = mem_word >> SLTG_USHIFT_SYMBOL;
			end
			SLTG_INJ_OCTET: begin
				width = SLTG_W_OCTET;
				mask = SLTG_MASK_OCTET;
				user_word = mem_word >> SLTG_USHIFT_OCTET;
			end
			default: begin
				width = SLTG_W_SAMPLE;
				mask = SLTG_MASK_SAMPLE;
				user_word = mem_word;
			end
		endcase
	end

	assign prbs_next = prbs_step(prbs_q, poly_of(mode), width);
	assign wr_poly = poly_of(reg_wdata[SLTG_MODE_MSB:SLTG_MODE_LSB]);

	always_comb begin
		pat_word = 16'h0000;
		unique case (mode)
			SLTG_MODE_CHECKER: pat_word = (phase_q ? SLTG_CHECKER_ODD : SLTG_CHECKER_EVEN) & mask;
			SLTG_MODE_TOGGLE: pat_word = (phase_q ? 16'hFFFF : 16'h0000) & mask;
			SLTG_MODE_PN31, SLTG_MODE_PN23, SLTG_MODE_PN15, SLTG_MODE_PN9, SLTG_MODE_PN7: begin
				pat_word = prbs_next.word & mask;
			end
			SLTG_MODE_RAMP: pat_word = ramp_q & mask;
			SLTG_MODE_USER_REPEAT: pat_word = user_word & mask;
			SLTG_MODE_USER_SINGLE: pat_word = single_done_q ? 16'h0000 : (user_word & mask);
			default: pat_word = 16'h0000;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_q <= SLTG_CTRL_RESET;
		end else if (soft_reset) begin
			ctrl_q <= SLTG_CTRL_RESET;
		end else if (ctrl_wr) begin
			ctrl_q <= reg_wdata & SLTG_CTRL_WR_MASK;
		end
	end

	// Sequence state restarts whenever the control register is written or soft reset.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prbs_q <= SLTG_SEED_PN31;
			ramp_q <= 16'h0000;
			phase_q <= 1'b0;
			uidx_q <= 2'h0;
			single_done_q <= 1'b0;
		end else if (ctrl_wr || soft_reset) begin
			prbs_q <= wr_poly.seed;
			ramp_q <= 16'h0000;
			phase_q <= 1'b0;
			uidx_q <= 2'h0;
			single_done_q <= 1'b0;
		end else if (word_advance && (mode != SLTG_MODE_OFF)) begin
			if (is_prbs) begin
				prbs_q <= prbs_next.state;
			end
			ramp_q <= (ramp_q + 16'h0001) & mask;
			phase_q <= !phase_q;
			uidx_q <= uidx_q + 2'h1;
			if (uidx_q == 2'h3) begin
				single_done_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			link_word_q <= 16'h0000;
			test_active_q <= 1'b0;
			inject_point_q <= 2'h0;
		end else begin
			test_active_q <= (mode != SLTG_MODE_OFF);
			inject_point_q <= inj;
			if (word_advance) begin
				link_word_q <= (mode != SLTG_MODE_OFF) ? pat_word : normal_word;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_pend_q <= 1'b0;
			rd_is_upat_q <= 1'b0;
			rd_hold_q <= 8'h00;
			reg_rdata_q <= 8'h00;
			reg_rvalid_q <= 1'b0;
		end else begin
			rd_pend_q <= reg_rd;
			rd_is_upat_q <= reg_rd && upat_hit_rd;
			rd_hold_q <= (reg_rd && (reg_addr == SLTG_ADDR_CTRL)) ? ctrl_q : 8'h00;
			reg_rvalid_q <= rd_pend_q;
			if (rd_pend_q) begin
				reg_rdata_q <= rd_is_upat_q ? mem_byte : rd_hold_q;
			end
		end
	end

endmodule

// *** shared/sltg_pkg.sv ***
// Package for the link test pattern generator: register map, field layout,
// mode codes, injection points and sequence seeds.
// Assumes a single clock domain and an 8-bit register port with 13-bit addresses.
package sltg_pkg;

	localparam logic [12:0] SLTG_ADDR_SOFT_RESET = 13'h0000;
	localparam logic [12:0] SLTG_ADDR_UPAT_BASE = 13'h0551;
	localparam logic [12:0] SLTG_ADDR_UPAT_LAST = 13'h0558;
	localparam logic [12:0] SLTG_ADDR_CTRL = 13'h0573;
	localparam logic [7:0] SLTG_SOFT_RESET_CODE = 8'h81;
	localparam logic [7:0] SLTG_CTRL_RESET = 8'h00;
	localparam logic [7:0] SLTG_CTRL_WR_MASK = 8'h3F;

	localparam int SLTG_MODE_LSB = 0;
	localparam int SLTG_MODE_MSB = 3;
	localparam int SLTG_INJ_LSB = 4;
	localparam int SLTG_INJ_MSB = 5;

	typedef enum logic [3:0] {
		SLTG_MODE_OFF = 4'h0,
		SLTG_MODE_CHECKER = 4'h1,
		SLTG_MODE_TOGGLE = 4'h2,
		SLTG_MODE_PN31 = 4'h3,
		SLTG_MODE_PN23 = 4'h4,
		SLTG_MODE_PN15 = 4'h5,
		SLTG_MODE_PN9 = 4'h6,
		SLTG_MODE_PN7 = 4'h7,
		SLTG_MODE_RAMP = 4'h8,
		SLTG_MODE_USER_REPEAT = 4'hE,
		SLTG_MODE_USER_SINGLE = 4'hF
	} sltg_mode_t;

	typedef enum logic [1:0] {
		SLTG_INJ_SAMPLE = 2'h0,
		SLTG_INJ_SYMBOL = 2'h1,
		SLTG_INJ_OCTET = 2'h2
	} sltg_inj_t;

	localparam logic [4:0] SLTG_W_SAMPLE = 5'd16;
	localparam logic [4:0] SLTG_W_SYMBOL = 5'd10;
	localparam logic [4:0] SLTG_W_OCTET = 5'd8;
	localparam logic [15:0] SLTG_MASK_SAMPLE = 16'hFFFF;
	localparam logic [15:0] SLTG_MASK_SYMBOL = 16'h03FF;
	localparam logic [15:0] SLTG_MASK_OCTET = 16'h00FF;
	localparam logic [15:0] SLTG_CHECKER_EVEN = 16'h5555;
	localparam logic [15:0] SLTG_CHECKER_ODD = 16'hAAAA;
	localparam logic [3:0] SLTG_USHIFT_SYMBOL = 4'h6;
	localparam logic [3:0] SLTG_USHIFT_OCTET = 4'h8;

	localparam logic [30:0] SLTG_SEED_PN31 = 31'h0003AFFF;
	localparam logic [30:0] SLTG_SEED_PN23 = 31'h0000_3AFF;
	localparam logic [30:0] SLTG_SEED_PN15 = 31'h0000_03AF;
	localparam logic [30:0] SLTG_SEED_PN9 = 31'h0000_0092;
	localparam logic [30:0] SLTG_SEED_PN7 = 31'h0000_0007;

	// Polynomial x^order + x^tap + 1.
	typedef struct packed {
		logic [4:0] order;
		logic [4:0] tap;
		logic [30:0] seed;
	} sltg_poly_t;

	typedef struct packed {
		logic [30:0] state;
		logic [15:0] word;
	} sltg_prbs_t;

	typedef struct packed {
		logic [15:0] word;
		logic active;
		sltg_inj_t inj;
	} sltg_out_t;

endpackage

// *** src/sltg_upat_mem.sv ***
// Four 16-bit user pattern words, written a byte at a time.
// Assumes byte index 0 is the low byte of word 0; both read ports are registered.
module sltg_upat_mem
	import sltg_pkg::*;
(
	input wire logic clk, // 20 MHz clock
	input wire logic reset_n, // asynchronous reset, active low
	input wire logic wr_en, // byte write strobe
	input wire logic [2:0] wr_byte, // byte index of the write
	input wire logic [7:0] wr_data, // byte to write
	input wire logic [2:0] rd_byte, // byte index for readback
	output logic [7:0] rd_byte_q, // registered readback byte
	input wire logic [1:0] rd_word, // word index for the generator
	output logic [15:0] rd_word_q // registered pattern word
);

	logic [7:0] mem_q [8];

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < 8; i++) begin
				mem_q[i] <= 8'h00;
			end
		end else if (wr_en) begin
			mem_q[wr_byte] <= wr_data;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_byte_q <= 8'h00;
			rd_word_q <= 16'h0000;
		end else begin
			rd_byte_q <= mem_q[rd_byte];
			rd_word_q <= {mem_q[{rd_word, 1'b1}], mem_q[{rd_word, 1'b0}]};
		end
	end

endmodule

// *** tb/sltg_top_checker.sv ***
// Port checker for the link test pattern generator.
// Assumes it is bound to sltg_top and shares its single clock and reset.
module sltg_top_checker
	import sltg_pkg::*;
#(
	parameter int SAMPLE_W = 16
) (
	input wire logic clk, // clock
	input wire logic reset_n, // reset, active low
	input wire logic [12:0] reg_addr, // register address
	input wire logic [7:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	input wire logic reg_rvalid_q, // read valid
	input wire logic word_advance, // word strobe
	input wire logic [15:0] normal_word, // normal data
	input wire logic [15:0] link_word_q, // output word
	input wire logic test_active_q, // test active
	input wire logic [1:0] inject_point_q // injection point
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] mode_q;
	wire ctl_wr = reg_wr && reg_addr == SLTG_ADDR_CTRL;
	wire rst_wr = reg_wr && reg_addr == SLTG_ADDR_SOFT_RESET && reg_wdata == SLTG_SOFT_RESET_CODE;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) mode_q <= 4'h0;
		else if (ctl_wr) mode_q <= reg_wdata[3:0];
		else if (rst_wr) mode_q <= 4'h0;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	rd_latency_a: assert property (reg_rd |-> ##2 reg_rvalid_q) else $error("read valid late");
	ctl_inj_a: assert property (ctl_wr |-> ##2 inject_point_q == 2'($past(reg_wdata, 2) >> 4))
		else $error("injection point not taken");
	word_hold_a: assert property (!word_advance |=> $stable(link_word_q)) else $error("word moved");
	pass_a: assert property (word_advance && mode_q == 4'h0 |=> link_word_q == $past(normal_word))
		else $error("normal data not passed");
	sym_chk_a: assert property (word_advance && mode_q == 4'h1 && inject_point_q == 2'h1
		|=> link_word_q == 16'h0155 || link_word_q == 16'h02AA) else $error("symbol checker wrong");
	oct_tog_a: assert property (word_advance && mode_q == 4'h2 && inject_point_q == 2'h2
		|=> link_word_q == 16'h0000 || link_word_q == 16'h00FF) else $error("octet toggle wrong");
	oct_width_a: assert property (word_advance && test_active_q && inject_point_q == 2'h2
		|=> link_word_q[15:8] == 8'h00) else $error("octet word too wide");
	soft_rst_a: assert property (rst_wr |-> ##2 !test_active_q && inject_point_q == 2'h0)
		else $error("soft reset ignored");
endmodule
bind sltg_top sltg_top_checker #(.SAMPLE_W(SAMPLE_W)) i_chk(.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rvalid_q(reg_rvalid_q),
	.word_advance(word_advance), .normal_word(normal_word), .link_word_q(link_word_q),
	.test_active_q(test_active_q), .inject_point_q(inject_point_q));

// *** tb/sltg_rx_model.sv ***
// Downstream receiver model: captures each word one cycle after it is launched.
// Assumes word_advance is the strobe that the generator also sees.
module sltg_rx_model (
	input wire logic clk, // clock
	input wire logic reset_n, // reset, active low
	input wire logic word_advance, // word strobe
	input wire logic [15:0] link_word_q, // generator output
	output logic [15:0] rx_word_q, // captured word
	output logic rx_valid_q // capture pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	logic adv_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			adv_q <= 1'b0;
			rx_valid_q <= 1'b0;
			rx_word_q <= 16'h0000;
		end else begin
			adv_q <= word_advance;
			rx_valid_q <= adv_q;
			if (adv_q) rx_word_q <= link_word_q;
		end
	end
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the link test pattern generator.
// Assumes the receiver model and the bound checker are compiled alongside.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import sltg_pkg::*;
	logic clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, word_advance = 0, reg_rvalid_q, test_active_q, rx_valid_q;
	logic [12:0] reg_addr = 0;
	logic [7:0] reg_wdata = 0, reg_rdata_q;
	logic [15:0] normal_word = 0, link_word_q, rx_word_q;
	logic [1:0] inject_point_q;
	logic [15:0] up[4];
	logic [30:0] pn;
	int bad_count = 0, checked = 0;
	int ml[10] = '{1, 2, 3, 4, 5, 6, 7, 8, 14, 15};
	sltg_top i_dut(.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .reg_rvalid_q,
		.word_advance, .normal_word, .link_word_q, .test_active_q, .inject_point_q);
	sltg_rx_model i_rx(.clk, .reset_n, .word_advance, .link_word_q, .rx_word_q, .rx_valid_q);
	initial forever #25 clk = ~clk;
	task step;
		@(posedge clk);
		#2;
	endtask
	task cmp(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task wr(input logic [12:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		step();
		reg_wr = 1'b0;
		step();
	endtask
	task rd(input logic [12:0] a, input logic [7:0] e);
		reg_addr = a;
		reg_rd = 1'b1;
		step();
		reg_rd = 1'b0;
		step();
		cmp({15'h0, reg_rvalid_q}, 16'h0001);
		step();
		cmp({8'h00, reg_rdata_q}, {8'h00, e});
	endtask
	task adv;
		word_advance = 1'b1;
		step();
		word_advance = 1'b0;
		step();
	endtask
	task go(input logic [7:0] c, input int n);
		int o, t, w;
		logic [15:0] e, mk, x;
		wr(SLTG_ADDR_CTRL, c);
		x = 16'h0000;
		w = c[5:4] == 2'h1 ? 10 : c[5:4] == 2'h2 ? 8 : 16;
		mk = 16'((32'h1 << w) - 1);
		case (c[3:0])
			4'h3: begin o = 31; t = 28; pn = SLTG_SEED_PN31; end
			4'h4: begin o = 23; t = 18; pn = SLTG_SEED_PN23; end
			4'h5: begin o = 15; t = 14; pn = SLTG_SEED_PN15; end
			4'h6: begin o = 9; t = 5; pn = SLTG_SEED_PN9; end
			default: begin o = 7; t = 6; pn = SLTG_SEED_PN7; end
		endcase
		for (int i = 0; i < n; i++) begin
			for (int b = 0; b < w; b++) begin
				x = {x[14:0], pn[0]};
				pn = (pn >> 1) | (31'(pn[0] ^ pn[o - t]) << (o - 1));
			end
			case (c[3:0])
				4'h1: e = i % 2 ? 16'hAAAA : 16'h5555;
				4'h2: e = i % 2 ? 16'hFFFF : 16'h0000;
				4'h8: e = 16'(i);
				4'hE: e = up[i%4] >> (16 - w);
				4'hF: e = i < 4 ? up[i%4] >> (16 - w) : 16'h0000;
				default: e = x;
			endcase
			adv();
			cmp(rx_word_q, e & mk);
		end
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		void'($urandom(46));
		repeat (20) @(posedge clk);
		#2;
		reset_n = 1'b1;
		step();
		rd(SLTG_ADDR_CTRL, SLTG_CTRL_RESET);
		for (int k = 0; k < 4; k++) begin
			up[k] = 16'($urandom);
			wr(13'(SLTG_ADDR_UPAT_BASE + 2 * k), up[k][7:0]);
			wr(13'(SLTG_ADDR_UPAT_BASE + 2 * k + 1), up[k][15:8]);
		end
		rd(SLTG_ADDR_UPAT_LAST, up[3][15:8]);
		go(8'h04, 0);
		foreach (ml[k]) begin
			wr(SLTG_ADDR_CTRL, {2'b00, 2'(k % 3), 4'(ml[k])});
			cmp({13'h0, inject_point_q, test_active_q}, {13'h0, 2'(k % 3), 1'b1});
		end
		go(8'h04, 4);
		cmp(rx_word_q, 16'h3D72);
		go(8'h26, 4);
		cmp(rx_word_q, 16'h00A9);
		foreach (ml[k]) for (int j = 0; j < 3; j++) go({2'b00, 2'(j), 4'(ml[k])}, ml[k] == 8 ? 260 : 12);
		wr(SLTG_ADDR_CTRL, 8'hFF);
		rd(SLTG_ADDR_CTRL, 8'hFF & SLTG_CTRL_WR_MASK);
		rd(13'h0574, 8'h00);
		wr(SLTG_ADDR_CTRL, 8'h09);
		adv();
		cmp(rx_word_q, 16'h0000);
		wr(SLTG_ADDR_SOFT_RESET, SLTG_SOFT_RESET_CODE);
		rd(SLTG_ADDR_CTRL, 8'h00);
		cmp({15'h0, test_active_q}, 16'h0000);
		normal_word = 16'($urandom);
		adv();
		cmp(rx_word_q, normal_word);
		cmp({15'h0, rx_valid_q}, 16'h0001);
		tally_and_finish();
	end
	initial begin
		#400000;
		bad_count++;
		tally_and_finish();
	end
endmodule
